/* File: verilog/cc_timer_defs.vh */
// constants for the capture/compare timer
`ifndef CC_TIMER_DEFS_VH
`define CC_TIMER_DEFS_VH
`define RUN_STOP      2'h0
`define RUN_FREE      2'h1
`define RUN_CLR_EDGE  2'h2
`define RUN_CLR_MATCH 2'h3
`define EDGE_FALL     2'h0
`define EDGE_RISE     2'h1
`define EDGE_NONE     2'h2
`define EDGE_BOTH     2'h3
`define CNT_ZERO      16'h0000
`define CNT_ONE       16'h0001
`define CNT_MAX       16'hFFFF
`define PRE_W         8
`define PRE_ONE       8'h01
`define PRE_ZERO      8'h00
`define FILT_SAMPLES  2
`endif

/* File: verilog/edge_filter.v */
// noise filter and edge detector for one timer input
`timescale 1ns/1ps
module edge_filter (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // sampling
  input  wire sample_en,
  input  wire din,
  // filtered edges, one-cycle pulses
  output reg  rise,
  output reg  fall
);
  reg [1:0] samp_reg;
  reg       level_reg;
  reg       primed_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_reg   <= 2'h0;
      level_reg  <= 1'b0;
      primed_reg <= 1'b0;
      rise       <= 1'b0;
      fall       <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (sample_en) begin
        samp_reg <= {samp_reg[0], din};
        // a level counts only after two equal samples in a row
        if (samp_reg[1] == samp_reg[0]) begin
          level_reg  <= samp_reg[0];
          primed_reg <= 1'b1;
          // no edge until a first stable level has been seen
          if (primed_reg && samp_reg[0] && !level_reg)
            rise <= 1'b1;
          if (primed_reg && !samp_reg[0] && level_reg)
            fall <= 1'b1;
        end
      end
    end
  end
endmodule // edge_filter

/* File: verilog/cc_timer.v */
// 16-bit capture/compare timer with filtered inputs and one-shot output
`timescale 1ns/1ps
`include "cc_timer_defs.vh"
module cc_timer #(
  parameter PRE_SEL_W = 3
) (
  // clock and reset
  input  wire                 clk,
  input  wire                 arst_n,
  // control
  input  wire [1:0]           run_mode,
  input  wire [PRE_SEL_W-1:0] prescale_sel,
  input  wire [1:0]           edge_select_a,
  input  wire [1:0]           edge_select_b,
  input  wire                 pin_function_a,
  input  wire                 pin_function_b,
  input  wire                 count_on_input_a,
  input  wire                 reverse_phase_capture_sel,
  input  wire                 compare_mode_a,
  input  wire                 compare_mode_b,
  input  wire                 oneshot_enable,
  input  wire                 oneshot_ext_enable,
  input  wire                 oneshot_software_trigger,
  input  wire                 overflow_clear,
  input  wire                 counter_read,
  // compare value writes
  input  wire                 write_a,
  input  wire                 write_b,
  input  wire [15:0]          write_data,
  // timer input pins
  input  wire                 timer_input_a,
  input  wire                 timer_input_b,
  // state and events
  output reg  [15:0]          main_counter,
  output reg  [15:0]          capture_compare_a,
  output reg  [15:0]          capture_compare_b,
  output reg                  overflow_flag,
  output reg                  capture_irq_a,
  output reg                  capture_irq_b,
  output reg                  oneshot_out
);
  reg        rst_s1_reg;
  reg        rst_n_reg;
  reg [`PRE_W-1:0] pre_reg;
  reg        cclk_rise_reg;
  reg        cclk_fall_reg;
  reg        pend_a_reg;
  reg        pend_b_reg;
  reg        ovf_window_reg;
  reg        shot_reg;
  reg        in_a_reg;
  reg        in_b_reg;

  wire a_rise;
  wire a_fall;
  wire b_rise;
  wire b_fall;
  wire running = (run_mode != `RUN_STOP);

  // reset release through two flops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // count clock: period of 2^(sel+1) main clocks, rise at wrap, fall halfway
  // one bit wider so the longest period still fits before the cut
  wire [`PRE_W:0]   pre_period = ({{`PRE_W{1'b0}}, 1'b1} << prescale_sel) << 1'b1;
  wire [`PRE_W:0]   pre_last_w = pre_period - {{`PRE_W{1'b0}}, 1'b1};
  wire [`PRE_W:0]   pre_half_w = (pre_period >> 1'b1) - {{`PRE_W{1'b0}}, 1'b1};
  wire [`PRE_W-1:0] pre_last   = pre_last_w[`PRE_W-1:0];
  wire [`PRE_W-1:0] pre_half   = pre_half_w[`PRE_W-1:0];
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pre_reg       <= `PRE_ZERO;
      cclk_rise_reg <= 1'b0;
      cclk_fall_reg <= 1'b0;
    end else begin
      cclk_rise_reg <= 1'b0;
      cclk_fall_reg <= 1'b0;
      if (!running) begin
        pre_reg <= `PRE_ZERO;
      end else begin
        pre_reg <= (pre_reg >= pre_last) ? `PRE_ZERO : pre_reg + `PRE_ONE;
        if (pre_reg >= pre_last)
          cclk_rise_reg <= 1'b1;
        if (pre_reg == pre_half)
          cclk_fall_reg <= 1'b1;
      end
    end
  end

  // pins register; a foreign pin function reads low
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      in_a_reg <= 1'b0;
      in_b_reg <= 1'b0;
    end else begin
      in_a_reg <= timer_input_a & pin_function_a;
      in_b_reg <= timer_input_b & pin_function_b;
    end
  end

  // filters stay in reset while stopped, so no edge is taken
  wire filt_rst_n = rst_n_reg & running;

  edge_filter u_filt_a (
    .clk       (clk),
    .rst_n     (filt_rst_n),
    .sample_en (count_on_input_a ? 1'b1 : cclk_fall_reg),
    .din       (in_a_reg),
    .rise      (a_rise),
    .fall      (a_fall)
  );

  edge_filter u_filt_b (
    .clk       (clk),
    .rst_n     (filt_rst_n),
    .sample_en (cclk_fall_reg),
    .din       (in_b_reg),
    .rise      (b_rise),
    .fall      (b_fall)
  );

  // valid and inverse edges by edge select
  reg a_valid;
  reg a_inverse;
  reg b_valid;
  always @* begin
    case (edge_select_a)
      `EDGE_FALL: begin a_valid = a_fall; a_inverse = a_rise; end
      `EDGE_RISE: begin a_valid = a_rise; a_inverse = a_fall; end
      `EDGE_BOTH: begin a_valid = a_rise | a_fall; a_inverse = 1'b0; end
      default:    begin a_valid = 1'b0; a_inverse = 1'b0; end
    endcase
    case (edge_select_b)
      `EDGE_FALL: b_valid = b_fall;
      `EDGE_RISE: b_valid = b_rise;
      `EDGE_BOTH: b_valid = b_rise | b_fall;
      default:    b_valid = 1'b0;
    endcase
  end

  // a count tick comes from input a edges or from the count clock rise
  wire tick = count_on_input_a ? a_valid : cclk_rise_reg;
  // input a is unusable as capture trigger when it drives the count
  wire a_trig_ok = !count_on_input_a;
  wire cap_b_trig = a_valid & a_trig_ok & !compare_mode_b;
  wire cap_a_trig = reverse_phase_capture_sel ? (a_inverse & a_trig_ok)
                                              : b_valid;
  wire cap_a_do = cap_a_trig & !compare_mode_a;
  // reverse-phase: b edge only flags interrupt a; capture a takes inverse a edges without an irq
  wire irq_a_ev = reverse_phase_capture_sel ? b_valid : cap_a_do;

  // one-shot triggers; not offered in match-clear mode
  wire shot_mode = (run_mode == `RUN_FREE) || (run_mode == `RUN_CLR_EDGE);
  wire ext_shot  = oneshot_enable & shot_mode & oneshot_ext_enable & a_valid;
  wire sw_shot   = oneshot_enable & shot_mode & oneshot_software_trigger & !shot_reg;

  wire at_max    = (main_counter == `CNT_MAX);
  wire match_a   = compare_mode_a & (main_counter == capture_compare_a);
  wire clr_edge  = (run_mode == `RUN_CLR_EDGE) & a_valid;
  wire clr_match = (run_mode == `RUN_CLR_MATCH) & match_a & tick;
  wire restart   = clr_edge | ext_shot | sw_shot;
  // a match at maximum in match-clear mode still counts as an overflow
  wire ovf_ev    = tick & at_max & !restart &
                   ((run_mode != `RUN_CLR_MATCH) ||
                    (capture_compare_a == `CNT_MAX));
  wire ovf_event_or_window;

  // counter
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      main_counter <= `CNT_ZERO;
    end else if (!running) begin
      main_counter <= `CNT_ZERO;
    end else if (restart || clr_match) begin
      main_counter <= `CNT_ZERO;
    end else if (tick) begin
      main_counter <= main_counter + `CNT_ONE;
    end
  end

  // overflow flag; a clear inside the window after wrap is dropped
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      overflow_flag  <= 1'b0;
      ovf_window_reg <= 1'b0;
    end else begin
      if (ovf_event_or_window)
        overflow_flag <= 1'b1;
      else if (overflow_clear)
        overflow_flag <= 1'b0;
      if (ovf_ev)
        ovf_window_reg <= 1'b1;
      else if (tick || restart || !running)
        ovf_window_reg <= 1'b0; // counter leaves zero, restarts or stops
    end
  end
  assign ovf_event_or_window = ovf_ev | ovf_window_reg;

  // capture/compare registers; counter_read has no path here
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      capture_compare_a <= `CNT_ZERO;
      capture_compare_b <= `CNT_ZERO;
    end else begin
      // captures land with the count clock fall, as the filters do
      if (cap_a_do)
        capture_compare_a <= main_counter;
      else if (write_a && compare_mode_a)
        capture_compare_a <= write_data;
      if (cap_b_trig)
        capture_compare_b <= main_counter;
      else if (write_b && compare_mode_b)
        capture_compare_b <= write_data;
      // contents simply left as they are on stop; software must not trust them
    end
  end

  // interrupts wait for the next count clock rise
  wire match_b = compare_mode_b & (main_counter == capture_compare_b) & tick;
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pend_a_reg    <= 1'b0;
      pend_b_reg    <= 1'b0;
      capture_irq_a <= 1'b0;
      capture_irq_b <= 1'b0;
    end else begin
      capture_irq_a <= 1'b0;
      capture_irq_b <= 1'b0;
      if (!running) begin
        pend_a_reg <= 1'b0;
        pend_b_reg <= 1'b0;
      end else begin
        if (cclk_rise_reg) begin
          capture_irq_a <= pend_a_reg | irq_a_ev | (match_a & tick);
          capture_irq_b <= pend_b_reg | cap_b_trig | match_b;
          pend_a_reg    <= 1'b0;
          pend_b_reg    <= 1'b0;
        end else begin
          // the clear at the rise always wins; an event in that cycle goes straight to the irq
          pend_a_reg <= pend_a_reg | irq_a_ev | (match_a & tick);
          pend_b_reg <= pend_b_reg | cap_b_trig | match_b;
        end
      end
    end
  end

  // one-shot: active from trigger until counter reaches register a,
  // output high once the counter has reached register b
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      shot_reg    <= 1'b0;
      oneshot_out <= 1'b0;
    end else begin
      if (!running || !shot_mode) begin
        shot_reg    <= 1'b0;
        oneshot_out <= 1'b0;
      end else if (ext_shot || sw_shot) begin
        shot_reg    <= 1'b1;
        oneshot_out <= 1'b0;
      end else if (shot_reg && tick) begin
        if (main_counter == capture_compare_a) begin
          shot_reg    <= 1'b0;
          oneshot_out <= 1'b0;
        end else if (main_counter == capture_compare_b) begin
          oneshot_out <= 1'b1;
        end
      end
    end
  end

  // counter_read is accepted only to show it touches nothing
  wire unused_read = counter_read;
endmodule // cc_timer

/* File: bench/pulse_source.sv */
// external pulse source driving the two timer input pins
`timescale 1ns/1ps
module pulse_source (
  // clock
  input  wire clk,
  // pins
  output reg  pin_a,
  output reg  pin_b
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // pins have no pull, so they are always driven to a level
  task pulse(input bit ch, input int hold);
    @(negedge clk);
    if (ch) pin_b = 1'b1; else pin_a = 1'b1;
    repeat (hold) @(negedge clk);
    if (ch) pin_b = 1'b0; else pin_a = 1'b0;
    repeat (hold) @(negedge clk);
  endtask
endmodule // pulse_source

/* File: bench/cc_timer_assertions.sv */
// port checks for the capture/compare timer
`timescale 1ns/1ps
module cc_timer_assertions (
  // clock and reset
  input wire        clk,
  input wire        arst_n,
  // control
  input wire [1:0]  run_mode,
  input wire        count_on_input_a,
  input wire        compare_mode_a,
  input wire        compare_mode_b,
  input wire        oneshot_enable,
  input wire        oneshot_ext_enable,
  input wire        overflow_clear,
  input wire        write_a,
  input wire        write_b,
  // state and events
  input wire [15:0] main_counter,
  input wire [15:0] capture_compare_a,
  input wire [15:0] capture_compare_b,
  input wire        overflow_flag,
  input wire        capture_irq_a,
  input wire        capture_irq_b,
  input wire        oneshot_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // zero count reached by a wrap, held until the counter moves on
  reg wrap_zero_reg;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      wrap_zero_reg <= 1'b0;
    else if (main_counter != 16'h0000 || run_mode != 2'h1 || oneshot_enable)
      wrap_zero_reg <= 1'b0;
    else if ($past(main_counter) == 16'hFFFF && $past(run_mode) == 2'h1)
      wrap_zero_reg <= 1'b1;
  end
  stop_zero_a: assert property (run_mode == 2'h0 && $past(run_mode) == 2'h0
    |-> main_counter == 16'h0000) else $error("counter not cleared");
  stop_quiet_a: assert property (run_mode == 2'h0 && $past(run_mode) == 2'h0
    |-> !capture_irq_a && !capture_irq_b) else $error("irq while stopped");
  // one-shot restarts may clear the counter, so leave them out
  count_step_a: assert property (run_mode == 2'h1 && $past(run_mode) == 2'h1
    && !count_on_input_a && !oneshot_enable && !oneshot_ext_enable
    && main_counter != $past(main_counter)
    |-> main_counter == $past(main_counter) + 16'h0001) else $error("bad count step");
  // restarts also bring the counter from maximum to zero, so leave them out
  ovf_set_a: assert property (run_mode == 2'h1 && $past(main_counter) == 16'hFFFF
    && $past(run_mode) == 2'h1 && !$past(oneshot_enable)
    && main_counter == 16'h0000 |-> ##[0:1] overflow_flag) else $error("no overflow");
  ovf_keep_a: assert property (run_mode == 2'h1 && main_counter == 16'h0000
    && !oneshot_enable && overflow_clear
    && (wrap_zero_reg || ($past(main_counter) == 16'hFFFF && $past(run_mode) == 2'h1
    && !$past(oneshot_enable))) |=> overflow_flag) else $error("clear took");
  cmp_hold_a_a: assert property (compare_mode_a && $past(compare_mode_a) && !write_a
    |=> $stable(capture_compare_a)) else $error("capture in compare a");
  cmp_hold_b_a: assert property (compare_mode_b && $past(compare_mode_b) && !write_b
    |=> $stable(capture_compare_b)) else $error("capture in compare b");
  match_shot_a: assert property (run_mode == 2'h3 && $past(run_mode) == 2'h3
    |-> !oneshot_out) else $error("one-shot in match mode");
  cover property (capture_irq_a);
  cover property (run_mode == 2'h2 && capture_irq_b);
  cover property (oneshot_out);
endmodule // cc_timer_assertions
bind cc_timer cc_timer_assertions cc_timer_assertions_inst (.clk, .arst_n, .run_mode,
  .count_on_input_a, .compare_mode_a, .compare_mode_b, .oneshot_enable,
  .oneshot_ext_enable, .overflow_clear, .write_a, .write_b, .main_counter,
  .capture_compare_a, .capture_compare_b, .overflow_flag, .capture_irq_a,
  .capture_irq_b, .oneshot_out);

/* File: bench/capture_compare_timer_cautions_bench.sv */
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module capture_compare_timer_cautions_bench;
  reg         clk, arst_n, pin_function_a, pin_function_b, count_on_input_a;
  reg  [1:0]  run_mode, edge_select_a, edge_select_b;
  reg  [2:0]  prescale_sel;
  reg         reverse_phase_capture_sel, compare_mode_a, compare_mode_b;
  reg         oneshot_enable, oneshot_ext_enable, oneshot_software_trigger;
  reg         overflow_clear, counter_read, write_a, write_b;
  reg  [15:0] write_data;
  wire        timer_input_a, timer_input_b, overflow_flag;
  wire        capture_irq_a, capture_irq_b, oneshot_out;
  wire [15:0] main_counter, capture_compare_a, capture_compare_b;
  reg  [15:0] saved;
  int         num_errors, checked, na, nb, k;
  cc_timer cc_timer_inst (.clk, .arst_n, .run_mode, .prescale_sel, .edge_select_a,
    .edge_select_b, .pin_function_a, .pin_function_b, .count_on_input_a,
    .reverse_phase_capture_sel, .compare_mode_a, .compare_mode_b, .oneshot_enable,
    .oneshot_ext_enable, .oneshot_software_trigger, .overflow_clear, .counter_read,
    .write_a, .write_b, .write_data, .timer_input_a, .timer_input_b, .main_counter,
    .capture_compare_a, .capture_compare_b, .overflow_flag, .capture_irq_a,
    .capture_irq_b, .oneshot_out);
  pulse_source pulse_source_inst (.clk, .pin_a(timer_input_a), .pin_b(timer_input_b));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // irqs last one cycle, so tally them where they are settled
  always @(negedge clk) begin
    na += (capture_irq_a === 1'b1);
    nb += (capture_irq_b === 1'b1);
  end
  task summarize;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task ok(input string n, input logic c);
    chk(n, 16'h0001, {15'h0, c});
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input bit b, input logic [15:0] d);
    cyc(1);
    write_data = d;
    if (b) write_b = 1'b1; else write_a = 1'b1;
    cyc(1);
    write_a = 1'b0;
    write_b = 1'b0;
  endtask
  // pulse a pin, then look for a capture irq within a bounded wait
  task trig(input bit ch, input bit b, input bit want);
    int s;
    s = b ? nb : na;
    pulse_source_inst.pulse(ch, 8);
    for (k = 0; k < 60 && (b ? nb : na) == s; k++) cyc(1);
    ok("capture irq", ((b ? nb : na) > s) == want);
    if (want && k == 60) summarize();
  endtask
  task strobe_shot;
    cyc(1);
    oneshot_software_trigger = 1'b1;
    cyc(1);
    oneshot_software_trigger = 1'b0;
  endtask
  initial begin
    {run_mode, edge_select_a, edge_select_b, prescale_sel, pin_function_a} = '0;
    {pin_function_b, count_on_input_a, reverse_phase_capture_sel, write_data} = '0;
    {compare_mode_a, compare_mode_b, oneshot_enable, oneshot_ext_enable} = '0;
    {oneshot_software_trigger, overflow_clear, counter_read, write_a, write_b} = '0;
    arst_n = 1'b0;
    cyc(5);
    arst_n = 1'b1;
    cyc(3);
    chk("counter", 16'h0000, main_counter);
    pin_function_a = 1'b1;
    pin_function_b = 1'b1;
    edge_select_a = 2'h1;
    edge_select_b = 2'h1;
    trig(1'b1, 1'b0, 1'b0);
    chk("cc a", 16'h0000, capture_compare_a);
    run_mode = 2'h1;
    cyc(20);
    ok("count", main_counter >= 16'h0008 && main_counter <= 16'h000B);
    trig(1'b1, 1'b0, 1'b1);
    ok("cc a", capture_compare_a > 16'h0000 && capture_compare_a < main_counter);
    counter_read = 1'b1;
    cyc(1);
    counter_read = 1'b0;
    chk("cc b", 16'h0000, capture_compare_b);
    compare_mode_b = 1'b1;
    wr(1'b1, 16'h1234);
    pulse_source_inst.pulse(1'b0, 8);
    cyc(20);
    chk("cc b", 16'h1234, capture_compare_b);
    run_mode = 2'h0;
    compare_mode_b = 1'b0;
    cyc(2);
    run_mode = 2'h2;
    cyc(200);
    trig(1'b0, 1'b1, 1'b1);
    ok("clear", main_counter < 16'h0020 && capture_compare_b > 16'h0040);
    run_mode = 2'h0;
    {compare_mode_a, compare_mode_b} = 2'b11;
    wr(1'b0, 16'h0040);
    wr(1'b1, 16'h0010);
    oneshot_enable = 1'b1;
    run_mode = 2'h1;
    strobe_shot();
    for (k = 0; k < 300 && oneshot_out !== 1'b1; k++) cyc(1);
    ok("one-shot", oneshot_out);
    if (k == 300) summarize();
    oneshot_ext_enable = 1'b1;
    pulse_source_inst.pulse(1'b0, 8);
    ok("restart", main_counter < 16'h0010);
    run_mode = 2'h0;
    oneshot_ext_enable = 1'b0;
    cyc(2);
    run_mode = 2'h3;
    strobe_shot();
    // a wrongly started shot would be high here, between its two marks
    cyc(60);
    ok("no shot", !oneshot_out);
    run_mode = 2'h0;
    oneshot_enable = 1'b0;
    {compare_mode_a, compare_mode_b} = 2'b00;
    pin_function_a = 1'b0;
    cyc(2);
    run_mode = 2'h1;
    trig(1'b0, 1'b1, 1'b0);
    // no scenario runs long enough to wrap the counter
    chk("overflow", 16'h0000, {15'h0, overflow_flag});
    run_mode = 2'h0;
    pin_function_a = 1'b1;
    reverse_phase_capture_sel = 1'b1;
    cyc(2);
    run_mode = 2'h1;
    saved = capture_compare_a;
    trig(1'b0, 1'b0, 1'b0);
    ok("cc a", capture_compare_a != saved);
    saved = capture_compare_a;
    trig(1'b1, 1'b0, 1'b1);
    chk("cc a", saved, capture_compare_a);
    run_mode = 2'h0;
    cyc(2);
    edge_select_a = 2'h3;
    run_mode = 2'h1;
    trig(1'b0, 1'b1, 1'b1);
    chk("cc a", saved, capture_compare_a);
    run_mode = 2'h0;
    cyc(2);
    edge_select_a = 2'h1;
    count_on_input_a = 1'b1;
    reverse_phase_capture_sel = 1'b0;
    saved = capture_compare_b;
    run_mode = 2'h1;
    pulse_source_inst.pulse(1'b0, 8);
    chk("counter", 16'h0001, main_counter);
    chk("cc b", saved, capture_compare_b);
    // one main-clock sample high is noise, not an edge
    pulse_source_inst.pulse(1'b0, 1);
    cyc(4);
    chk("counter", 16'h0001, main_counter);
    summarize();
  end
endmodule // capture_compare_timer_cautions_bench
